// *** logic/socr_pkg.sv ***
// Constants for the serial output configuration register bank.
// Assumes a byte-wide register port decoded by the serial control port.
package socr_pkg;
  localparam logic [7:0] SOCR_ADDR_DRV_CTRL = 8'h18;
  localparam logic [7:0] SOCR_ADDR_DRV_RDBK = 8'h19;
  localparam logic [7:0] SOCR_ADDR_VERSION = 8'h1E;
  localparam logic [7:0] SOCR_DRV_CTRL_RESET = 8'h00;
  localparam int SOCR_BIT_SLVS = 0;
  localparam int SOCR_BIT_CM = 1;
  localparam int SOCR_BIT_DRIVE_LO = 2;
  localparam int SOCR_BIT_TERM = 4;
  localparam logic [1:0] SOCR_DRIVE_2P5 = 2'h0;
  localparam logic [1:0] SOCR_DRIVE_3P5 = 2'h1;
  localparam logic [1:0] SOCR_DRIVE_RSVD = 2'h2;
  localparam logic [1:0] SOCR_DRIVE_5P0 = 2'h3;
  localparam logic [1:0] SOCR_CM_1V0 = 2'h0;
  localparam logic [1:0] SOCR_CM_1V25 = 2'h1;
  localparam logic [1:0] SOCR_CM_SLVS = 2'h2;
  // Arbitrary version value, not tied to any real part.
  localparam logic [7:0] SOCR_VERSION_DEFAULT = 8'h12;
endpackage

// *** logic/socr_regs.sv ***
// Output driver configuration and chip version register bank.
// Assumes the serial control port presents decoded byte writes and reads.
// Behaviour
// (R1) The control register at 18h is write-only and 19h reads back its contents.
// (R2) Software writes zeros to control bits 7:5, which are reserved.
// (R3) Bit 4 enables the internal 100 ohm data output termination when one.
// (R4) Bits 3:2 set drive current 2.5, 3.5 or 5 mA, with code 10 reserved.
// (R5) In LVDS mode bit 1 selects 1.0V common mode when clear and 1.25V when set.
// (R6) In SLVS mode bit 1 is ignored and the fixed SLVS common mode is used.
// (R7) Software clears bit 1 for a 1.2V driver supply and sets it for 1.8V.
// (R8) Bit 0 selects LVDS when zero and SLVS when one.
// (R9) Register 1Eh is read-only and returns the eight-bit chip version in two nibbles.
// (R10) The control register resets to zero: LVDS, 2.5 mA, 1.0V, termination off.
`timescale 1ns/1ps
module socr_regs #(
  parameter logic [7:0] VERSION = socr_pkg::SOCR_VERSION_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic term_enable,
  output logic [1:0] drive_select,
  output logic [1:0] common_mode_select,
  output logic slvs_select,
  output logic [3:0] version_major,
  output logic [3:0] version_minor
);
  import socr_pkg::*;

  // ********************************************************************
  // Control register
  // ********************************************************************
  logic [7:0] drv_ctrl_ff;
  logic [7:0] nxt_drv_ctrl;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_drv_ctrl = drv_ctrl_ff;
    // (R1) Write-only control register.
    if (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL) begin
      nxt_drv_ctrl = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    // (R10) Reset to zero.
    if (rst) begin
      drv_ctrl_ff <= SOCR_DRV_CTRL_RESET;
    end else begin
      drv_ctrl_ff <= nxt_drv_ctrl;
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  // The control address itself reads as zero because the register is write-only.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      // (R1) Readback at 19h.
      if (reg_addr == SOCR_ADDR_DRV_RDBK) begin
        nxt_rdata = drv_ctrl_ff;
      // (R9) Version register read.
      end else if (reg_addr == SOCR_ADDR_VERSION) begin
        nxt_rdata = VERSION;
      end else begin
        nxt_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ********************************************************************
  // Driver controls
  // ********************************************************************
  // Reserved bits 7:5 are stored and read back but steer nothing.
  // (R3) Termination enable.
  assign term_enable = drv_ctrl_ff[SOCR_BIT_TERM];
  // (R4) Drive current code, passed raw; code 10 is left to software.
  assign drive_select = drv_ctrl_ff[SOCR_BIT_DRIVE_LO +: 2];
  // (R8) Signalling standard.
  assign slvs_select = drv_ctrl_ff[SOCR_BIT_SLVS];
  // (R9) Version nibbles.
  assign version_major = VERSION[7:4];
  assign version_minor = VERSION[3:0];

  // (R5) (R6) Common mode choice, SLVS overrides.
  function automatic logic [1:0] cm_decode(input logic [7:0] ctrl);
    logic [1:0] cm;
    if (ctrl[SOCR_BIT_SLVS]) begin
      cm = SOCR_CM_SLVS;
    end else if (ctrl[SOCR_BIT_CM]) begin
      cm = SOCR_CM_1V25;
    end else begin
      cm = SOCR_CM_1V0;
    end
    return cm;
  endfunction

  // The level is decoded from the next control value, so it moves on the same edge as the
  // raw fields yet still leaves the block from a flip-flop.
  logic [1:0] cm_ff;
  logic [1:0] nxt_cm;

  // (R5) (R6) Next common mode.
  always_comb begin
    nxt_cm = cm_decode(nxt_drv_ctrl);
  end

  always_ff @(posedge ref_clk) begin
    // (R10) Reset to 1.0V.
    if (rst) begin
      cm_ff <= SOCR_CM_1V0;
    end else begin
      cm_ff <= nxt_cm;
    end
  end

  assign common_mode_select = cm_ff;

  // ********************************************************************
  // Checks
  // ********************************************************************
  // Seven of the properties take their reference from the bus inputs rather than the stored byte,
  // so a slip in the stored value or in the decode does not agree with itself.
  // (R1) Control write lands.
  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL) |=> drv_ctrl_ff == $past(reg_wdata))
    else $error("Control register does not hold the written byte.");

  // (R1) Other writes ignored.
  a_ctrl_holds: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    !(reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL) |=> $stable(drv_ctrl_ff))
    else $error("Control register changed without a control write.");

  // (R1) Write then readback.
  a_write_readback: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL)
      ##1 (reg_rd && reg_addr == SOCR_ADDR_DRV_RDBK && !reg_wr)
      |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Readback does not match last control write.");

  // (R1) Readback returns contents.
  a_rdbk_value: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    (reg_rd && reg_addr == SOCR_ADDR_DRV_RDBK) |=> reg_rdata == $past(drv_ctrl_ff))
    else $error("Readback does not return the control register.");

  // (R1) Write-only reads zero.
  a_wo_reads_zero: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    (reg_rd && reg_addr != SOCR_ADDR_DRV_RDBK && reg_addr != SOCR_ADDR_VERSION)
      |=> reg_rdata == 8'h00)
    else $error("Read of a write-only or unmapped address is not zero.");

  // (R1) Read data stands.
  a_rdata_holds: assert property (@(posedge ref_clk) disable iff (rst) // (R1)
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read.");

  // (R3) Termination follows write.
  a_term_follows: assert property (@(posedge ref_clk) disable iff (rst) // (R3)
    (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL)
      |=> term_enable == $past(reg_wdata[SOCR_BIT_TERM]))
    else $error("Termination enable does not follow written bit.");

  // (R3) Controls hold between writes.
  a_outputs_hold: assert property (@(posedge ref_clk) disable iff (rst) // (R3)
    !(reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL)
      |=> $stable(term_enable) && $stable(drive_select) && $stable(slvs_select)
        && $stable(common_mode_select))
    else $error("Driver controls changed without a control write.");

  // (R4) Drive code follows write.
  a_drive_follows: assert property (@(posedge ref_clk) disable iff (rst) // (R4)
    (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL)
      |=> drive_select == $past(reg_wdata[SOCR_BIT_DRIVE_LO +: 2]))
    else $error("Drive code does not follow written field.");

  // (R5) LVDS common mode.
  a_cm_lvds: assert property (@(posedge ref_clk) disable iff (rst) // (R5)
    !slvs_select |-> common_mode_select
      == (drv_ctrl_ff[SOCR_BIT_CM] ? SOCR_CM_1V25 : SOCR_CM_1V0))
    else $error("LVDS common mode wrong.");

  // (R5) LVDS level from write.
  a_cm_lvds_write: assert property (@(posedge ref_clk) disable iff (rst) // (R5)
    (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL && !reg_wdata[SOCR_BIT_SLVS])
      |=> common_mode_select == ($past(reg_wdata[SOCR_BIT_CM]) ? SOCR_CM_1V25 : SOCR_CM_1V0))
    else $error("LVDS common mode does not follow the written bit.");

  // (R6) SLVS fixed level.
  a_cm_slvs: assert property (@(posedge ref_clk) disable iff (rst) // (R6)
    slvs_select |-> common_mode_select == SOCR_CM_SLVS)
    else $error("SLVS common mode not fixed.");

  // (R6) SLVS ignores select.
  a_cm_slvs_write: assert property (@(posedge ref_clk) disable iff (rst) // (R6)
    (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL && reg_wdata[SOCR_BIT_SLVS])
      |=> common_mode_select == SOCR_CM_SLVS)
    else $error("SLVS write did not give the fixed common mode.");

  // (R8) Signalling follows write.
  a_slvs_follows: assert property (@(posedge ref_clk) disable iff (rst) // (R8)
    (reg_wr && reg_addr == SOCR_ADDR_DRV_CTRL)
      |=> slvs_select == $past(reg_wdata[SOCR_BIT_SLVS]))
    else $error("Signalling select does not follow written bit.");

  // (R9) Version read value.
  a_version_read: assert property (@(posedge ref_clk) disable iff (rst) // (R9)
    (reg_rd && reg_addr == SOCR_ADDR_VERSION) |=> reg_rdata == VERSION)
    else $error("Version read wrong.");

  // (R10) Reset clears register.
  a_reset_zero: assert property (@(posedge ref_clk) // (R10)
    rst |=> drv_ctrl_ff == SOCR_DRV_CTRL_RESET && reg_rdata == 8'h00)
    else $error("Control register not zero after reset.");

  // (R10) Reset default controls.
  a_reset_outputs: assert property (@(posedge ref_clk) // (R10)
    rst |=> !term_enable && drive_select == SOCR_DRIVE_2P5
      && common_mode_select == SOCR_CM_1V0 && !slvs_select)
    else $error("Driver controls not at their defaults after reset.");
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the output driver configuration register bank.
// Assumes socr_pkg is compiled first and that the bank asserts its own timing.
`timescale 1ns/1ps
module tb;
  import socr_pkg::*;
  // ****************************************
  // Clock, reset and design instance
  // ****************************************
  localparam logic [7:0] VER = 8'hA5; // Arbitrary version value, not tied to any real part.
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic term_enable, slvs_select;
  logic [1:0] drive_select, common_mode_select;
  logic [3:0] version_major, version_minor;
  int failures = 0, comparisons = 0;
  logic [7:0] pats [5] = '{8'h11, 8'h06, 8'h1C, 8'h03, 8'h02};
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  socr_regs #(.VERSION(VER)) DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .term_enable(term_enable), .drive_select(drive_select),
    .common_mode_select(common_mode_select), .slvs_select(slvs_select),
    .version_major(version_major), .version_minor(version_minor));
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    cmp(reg_rdata, exp, "read data");
  endtask
  // A control write followed at the very next edge by a read, as the port allows.
  task automatic wr_rd(input logic [7:0] wa, input logic [7:0] d, input logic [7:0] ra,
    input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= wa;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ra;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    cmp(reg_rdata, exp, "back-to-back read data");
  endtask
  // The expected common mode falls back to the fixed level whenever SLVS is chosen.
  task automatic chk(input logic [7:0] d);
    logic [1:0] cm;
    cm = d[0] ? SOCR_CM_SLVS : (d[1] ? SOCR_CM_1V25 : SOCR_CM_1V0);
    @(negedge ref_clk);
    cmp({7'h00, term_enable}, {7'h00, d[4]}, "termination");
    cmp({6'h00, drive_select}, {6'h00, d[3:2]}, "drive code");
    cmp({6'h00, common_mode_select}, {6'h00, cm}, "common mode");
    cmp({7'h00, slvs_select}, {7'h00, d[0]}, "signalling");
  endtask
  task automatic complete_run;
    $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // Test sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    chk(SOCR_DRV_CTRL_RESET); // reset outputs
    rd(SOCR_ADDR_DRV_RDBK, 8'h00); // reset readback
    $display("Test reset defaults done");
    foreach (pats[i]) begin
      wr(SOCR_ADDR_DRV_CTRL, pats[i]); // reserved bits zero
      chk(pats[i]);
      rd(SOCR_ADDR_DRV_RDBK, pats[i]); // readback copy
    end
    rd(SOCR_ADDR_DRV_CTRL, 8'h00); // write-only address
    $display("Test field decode done");
    wr(SOCR_ADDR_DRV_RDBK, 8'h1F); // readback not writable
    wr(SOCR_ADDR_VERSION, 8'h00); // version not writable
    wr(8'h40, 8'h1F); // unmapped write
    chk(8'h02); // unmapped writes ignored
    rd(8'h40, 8'h00); // unmapped read
    rd(SOCR_ADDR_VERSION, VER); // version value
    cmp({version_major, version_minor}, VER, "version nibbles"); // nibble split
    $display("Test read-only places done");
    wr(SOCR_ADDR_DRV_CTRL, 8'h1D); // control write between reads
    chk(8'h1D);
    cmp(reg_rdata, VER, "held read data"); // read data stands
    wr_rd(SOCR_ADDR_DRV_CTRL, 8'h0E, SOCR_ADDR_DRV_RDBK, 8'h0E); // back-to-back
    chk(8'h0E);
    $display("Test back-to-back done");
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    chk(SOCR_DRV_CTRL_RESET); // second reset
    cmp(reg_rdata, 8'h00, "read data after reset"); // read data cleared
    rd(SOCR_ADDR_DRV_RDBK, 8'h00); // second reset readback
    $display("Test mid-run reset done");
    complete_run();
  end
  // A hang past many times the expected length of the tests ends the run.
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
